// File: rtl/spo_step_path.sv
// Stepper pulse output path of one axis with its APB register file
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "spo_defs.svh"
module spo_step_path
(
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic enc_a,
  input wire logic enc_b,
  output logic step_out,
  output logic dir_out,
  output logic after_profile,
  output logic motion_complete
);
  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  function automatic logic spo_mapped(input logic [7:0] addr);
    case (addr)
      `SPO_OFS_CTRL, `SPO_OFS_STEP_SMOOTH, `SPO_OFS_PROF_SMOOTH,
      `SPO_OFS_SPEED, `SPO_OFS_MOVE, `SPO_OFS_DEF_REF,
      `SPO_OFS_REF_POS, `SPO_OFS_STEP_COUNT, `SPO_OFS_ENC_POS,
      `SPO_OFS_STATUS:
        spo_mapped = 1'b1;
      default:
        spo_mapped = 1'b0;
    endcase
  endfunction

  logic setup_phase;
  logic wr_en;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  assign setup_phase = psel && !penable;
  assign wr_en = psel && penable && pwrite && spo_mapped(paddr);
  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !spo_mapped(paddr);
  assign prdata = rdata_q;

  // ----------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------
  spo_pkg::spo_motor_e motor_q;
  logic [3:0] step_shift_q;
  logic [3:0] prof_shift_q;
  logic [15:0] speed_q;
  logic is_stepper;
  logic active_low;
  logic reversed;
  logic [3:0] step_shift_eff;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      motor_q <= spo_pkg::SPO_MT_SERVO;
      step_shift_q <= `SPO_RST_STEP_SMOOTH;
      prof_shift_q <= `SPO_RST_PROF_SMOOTH;
      speed_q <= `SPO_RST_SPEED;
    end
    else if (wr_en)
    begin
      case (paddr)
        `SPO_OFS_CTRL:
        begin
          motor_q <= spo_pkg::spo_motor_e'(pwdata[`SPO_MT_MSB:`SPO_MT_LSB]);
        end
        `SPO_OFS_STEP_SMOOTH:
        begin
          step_shift_q <= pwdata[`SPO_SHIFT_MSB:`SPO_SHIFT_LSB];
        end
        `SPO_OFS_PROF_SMOOTH:
        begin
          prof_shift_q <= pwdata[`SPO_SHIFT_MSB:`SPO_SHIFT_LSB];
        end
        `SPO_OFS_SPEED:
        begin
          speed_q <= pwdata[`SPO_SPEED_MSB:0];
        end
        default:
        begin
        end
      endcase
    end
  end

  always_comb
  begin
    is_stepper = 1'b1;
    active_low = 1'b0;
    reversed = 1'b0;
    case (motor_q)
      spo_pkg::SPO_MT_LOW:
        active_low = 1'b1;
      spo_pkg::SPO_MT_HIGH:
        active_low = 1'b0;
      spo_pkg::SPO_MT_LOW_REV:
      begin
        active_low = 1'b1;
        reversed = 1'b1;
      end
      spo_pkg::SPO_MT_HIGH_REV:
        reversed = 1'b1;
      default:
        is_stepper = 1'b0;
    endcase
  end

  assign step_shift_eff = (step_shift_q == 4'h0) ? 4'h1 : step_shift_q;

  // ----------------------------------------------------------------
  // Profiler and reference position
  // ----------------------------------------------------------------
  spo_pkg::spo_pos_t target_q;
  spo_pkg::spo_pos_t ref_pos_q;
  logic [15:0] rate_cnt_q;
  logic def_ref;
  logic prof_tick;
  logic prof_done;

  assign def_ref = wr_en && (paddr == `SPO_OFS_DEF_REF);
  assign prof_tick = (rate_cnt_q == 16'h0000);
  assign prof_done = (ref_pos_q == target_q);

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      target_q <= 32'sh0;
    end
    else if (def_ref)
    begin
      target_q <= pwdata;
    end
    else if (wr_en && paddr == `SPO_OFS_MOVE)
    begin
      target_q <= target_q + $signed(pwdata);
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset || prof_tick)
    begin
      rate_cnt_q <= reset ? 16'h0000 : speed_q;
    end
    else
    begin
      rate_cnt_q <= rate_cnt_q - 16'h0001;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      ref_pos_q <= 32'sh0;
    end
    else if (def_ref)
    begin
      ref_pos_q <= pwdata;
    end
    // Profiler runs in every mode so the after-profile trippoint works too
    else if (prof_tick && !prof_done)
    begin
      ref_pos_q <= (target_q > ref_pos_q) ? ref_pos_q + 32'sh1
                                          : ref_pos_q - 32'sh1;
    end
  end

  // ----------------------------------------------------------------
  // Smoothing filters
  // ----------------------------------------------------------------
  logic [15:0] sample_cnt_q;
  logic sample;

  assign sample = (sample_cnt_q == 16'h0000);

  always_ff @(posedge clock)
  begin
    if (reset || sample)
    begin
      sample_cnt_q <= 16'(`SPO_SAMPLE_CYC - 1);
    end
    else
    begin
      sample_cnt_q <= sample_cnt_q - 16'h0001;
    end
  end

  spo_flt_if prof_if ();
  spo_flt_if step_if ();

  assign prof_if.sample = sample;
  assign prof_if.shift = prof_shift_q;
  assign prof_if.load = def_ref;
  assign prof_if.load_pos = pwdata;
  assign prof_if.in_pos = ref_pos_q;

  assign step_if.sample = sample;
  assign step_if.shift = step_shift_eff;
  assign step_if.load = def_ref;
  assign step_if.load_pos = pwdata;
  assign step_if.in_pos = prof_if.out_pos;

  spo_smooth_filter u_prof_filter
  (
    .clock(clock),
    .reset(reset),
    .port_if(prof_if.flt)
  );

  spo_smooth_filter u_step_filter
  (
    .clock(clock),
    .reset(reset),
    .port_if(step_if.flt)
  );

  // ----------------------------------------------------------------
  // Output buffer and step generator
  // ----------------------------------------------------------------
  spo_pkg::spo_step_e state_q;
  spo_pkg::spo_step_e state_d;
  spo_pkg::spo_pos_t step_cnt_q;
  logic [7:0] tmr_q;
  logic [7:0] tmr_d;
  logic dir_q;
  logic dir_d;
  logic want_up;
  logic pending;
  logic step_fire;
  logic step_q;
  logic dir_pin_q;

  assign pending = is_stepper && (step_if.out_pos != step_cnt_q);
  assign want_up = step_if.out_pos > step_cnt_q;

  always_comb
  begin
    state_d = state_q;
    tmr_d = (tmr_q == 8'h00) ? 8'h00 : tmr_q - 8'h01;
    dir_d = dir_q;
    step_fire = 1'b0;
    case (state_q)
      spo_pkg::SPO_ST_IDLE:
      begin
        if (pending && want_up != dir_q)
        begin
          dir_d = want_up;
          state_d = spo_pkg::SPO_ST_DIR;
          tmr_d = 8'(`SPO_DIR_SETUP_CYC - 1);
        end
        else if (pending)
        begin
          step_fire = 1'b1;
          state_d = spo_pkg::SPO_ST_PULSE;
          tmr_d = 8'(`SPO_STEP_CYC - 1);
        end
      end
      spo_pkg::SPO_ST_DIR:
      begin
        if (tmr_q == 8'h00)
        begin
          state_d = spo_pkg::SPO_ST_IDLE;
        end
      end
      spo_pkg::SPO_ST_PULSE:
      begin
        if (tmr_q == 8'h00)
        begin
          state_d = spo_pkg::SPO_ST_GAP;
          tmr_d = 8'(`SPO_STEP_CYC - 1);
        end
      end
      spo_pkg::SPO_ST_GAP:
      begin
        if (tmr_q == 8'h00)
        begin
          state_d = spo_pkg::SPO_ST_IDLE;
        end
      end
      default:
        state_d = spo_pkg::SPO_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_q <= spo_pkg::SPO_ST_IDLE;
      tmr_q <= 8'h00;
      dir_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      tmr_q <= tmr_d;
      dir_q <= dir_d;
    end
  end

  // Count of pulses leaving the buffer
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      step_cnt_q <= 32'sh0;
    end
    else if (def_ref)
    begin
      step_cnt_q <= pwdata;
    end
    else if (step_fire)
    begin
      step_cnt_q <= dir_q ? step_cnt_q + 32'sh1 : step_cnt_q - 32'sh1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      step_q <= 1'b0;
      dir_pin_q <= 1'b0;
    end
    else
    begin
      step_q <= (state_d == spo_pkg::SPO_ST_PULSE) ^ active_low;
      dir_pin_q <= dir_d ^ reversed;
    end
  end

  assign step_out = step_q;
  assign dir_out = dir_pin_q;

  // ----------------------------------------------------------------
  // Completion status
  // ----------------------------------------------------------------
  logic after_q;
  logic done_q;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      after_q <= 1'b1;
      done_q <= 1'b1;
    end
    else
    begin
      after_q <= prof_done;
      done_q <= prof_done && step_cnt_q == target_q &&
                state_q == spo_pkg::SPO_ST_IDLE && !step_fire;
    end
  end

  assign after_profile = after_q;
  assign motion_complete = done_q;

  // ----------------------------------------------------------------
  // Main encoder
  // ----------------------------------------------------------------
  // Only the main input exists; nothing auxiliary is decoded
  logic [1:0] enc_raw;
  logic [1:0] enc_s1_q;
  logic [1:0] enc_s2_q;
  logic [1:0] enc_prev_q;
  spo_pkg::spo_pos_t enc_pos_q;
  logic a_chg;
  logic b_chg;

  assign enc_raw = {enc_b, enc_a};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_sync
      always_ff @(posedge clock)
      begin
        if (reset)
        begin
          enc_s1_q[gi] <= 1'b0;
          enc_s2_q[gi] <= 1'b0;
          enc_prev_q[gi] <= 1'b0;
        end
        else
        begin
          enc_s1_q[gi] <= enc_raw[gi];
          enc_s2_q[gi] <= enc_s1_q[gi];
          enc_prev_q[gi] <= enc_s2_q[gi];
        end
      end
    end
  endgenerate

  assign a_chg = enc_s2_q[0] ^ enc_prev_q[0];
  assign b_chg = enc_s2_q[1] ^ enc_prev_q[1];

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      enc_pos_q <= 32'sh0;
    end
    else if (wr_en && paddr == `SPO_OFS_ENC_POS)
    begin
      enc_pos_q <= pwdata;
    end
    // A double transition is a lost edge and is dropped
    else if (a_chg ^ b_chg)
    begin
      enc_pos_q <= (enc_s2_q[0] ^ enc_prev_q[1]) ? enc_pos_q + 32'sh1
                                                 : enc_pos_q - 32'sh1;
    end
  end

  // Encoder count feeds only the read path, never the profiler

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    case (paddr)
      `SPO_OFS_CTRL:
        rdata_d[`SPO_MT_MSB:`SPO_MT_LSB] = motor_q;
      `SPO_OFS_STEP_SMOOTH:
        rdata_d[`SPO_SHIFT_MSB:`SPO_SHIFT_LSB] = step_shift_q;
      `SPO_OFS_PROF_SMOOTH:
        rdata_d[`SPO_SHIFT_MSB:`SPO_SHIFT_LSB] = prof_shift_q;
      `SPO_OFS_SPEED:
        rdata_d[`SPO_SPEED_MSB:0] = speed_q;
      `SPO_OFS_MOVE:
        rdata_d = target_q;
      `SPO_OFS_DEF_REF, `SPO_OFS_REF_POS:
        rdata_d = ref_pos_q;
      `SPO_OFS_STEP_COUNT:
        rdata_d = step_cnt_q;
      `SPO_OFS_ENC_POS:
        rdata_d = enc_pos_q;
      `SPO_OFS_STATUS:
      begin
        rdata_d[`SPO_ST_AFTER_PROFILE] = after_q;
        rdata_d[`SPO_ST_STEPS_DONE] = done_q;
        rdata_d[`SPO_ST_STEP_BUSY] = (state_q != spo_pkg::SPO_ST_IDLE);
      end
      default:
        rdata_d = 32'h0000_0000;
    endcase
  end

  // Captured in the setup cycle so the answer comes from a flop
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (setup_phase && !pwrite)
    begin
      rdata_q <= spo_mapped(paddr) ? rdata_d : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// File: include/spo_defs.svh
// Offsets, field positions, reset values and timing counts of the step path
`ifndef SPO_DEFS_SVH
`define SPO_DEFS_SVH
`define SPO_CLK_MHZ 50
`define SPO_SAMPLE_NS 1000
`define SPO_SAMPLE_CYC ((`SPO_SAMPLE_NS * `SPO_CLK_MHZ + 999) / 1000)
`define SPO_DIR_SETUP_NS 1000
`define SPO_DIR_SETUP_CYC ((`SPO_DIR_SETUP_NS * `SPO_CLK_MHZ + 999) / 1000)
`define SPO_STEP_NS 2000
`define SPO_STEP_CYC ((`SPO_STEP_NS * `SPO_CLK_MHZ + 999) / 1000)
`define SPO_OFS_CTRL 8'h00
`define SPO_OFS_STEP_SMOOTH 8'h04
`define SPO_OFS_PROF_SMOOTH 8'h08
`define SPO_OFS_SPEED 8'h0C
`define SPO_OFS_MOVE 8'h10
`define SPO_OFS_DEF_REF 8'h14
`define SPO_OFS_REF_POS 8'h18
`define SPO_OFS_STEP_COUNT 8'h1C
`define SPO_OFS_ENC_POS 8'h20
`define SPO_OFS_STATUS 8'h24
`define SPO_MT_LSB 0
`define SPO_MT_MSB 2
`define SPO_SHIFT_LSB 0
`define SPO_SHIFT_MSB 3
`define SPO_SPEED_MSB 15
`define SPO_ST_AFTER_PROFILE 0
`define SPO_ST_STEPS_DONE 1
`define SPO_ST_STEP_BUSY 2
`define SPO_RST_STEP_SMOOTH 4'h4
`define SPO_RST_PROF_SMOOTH 4'h0
`define SPO_RST_SPEED 16'h03E8
`endif

// File: include/spo_pkg.sv
// Types shared by the step path modules
package spo_pkg;
  typedef enum logic [2:0]
  {
    SPO_MT_SERVO = 3'h0,
    SPO_MT_LOW = 3'h1,
    SPO_MT_HIGH = 3'h2,
    SPO_MT_LOW_REV = 3'h3,
    SPO_MT_HIGH_REV = 3'h4
  } spo_motor_e;
  typedef enum logic [3:0]
  {
    SPO_ST_IDLE = 4'h1,
    SPO_ST_DIR = 4'h2,
    SPO_ST_PULSE = 4'h4,
    SPO_ST_GAP = 4'h8
  } spo_step_e;
  typedef logic signed [31:0] spo_pos_t;
endpackage

// File: include/spo_flt_if.sv
// Connection between the step path and one smoothing filter
`timescale 1ns/100ps
`default_nettype none
interface spo_flt_if;
  logic sample;
  logic [3:0] shift;
  logic load;
  spo_pkg::spo_pos_t load_pos;
  spo_pkg::spo_pos_t in_pos;
  spo_pkg::spo_pos_t out_pos;
  modport flt (input sample, input shift, input load, input load_pos,
               input in_pos, output out_pos);
  modport ctl (output sample, output shift, output load, output load_pos,
               output in_pos, input out_pos);
endinterface
`default_nettype wire

// File: rtl/spo_smooth_filter.sv
// Single-pole smoothing filter acting on a position value
`timescale 1ns/100ps
`default_nettype none
module spo_smooth_filter
(
  input wire logic clock,
  input wire logic reset,
  spo_flt_if.flt port_if
);
  // Position with 16 fraction bits
  logic signed [47:0] acc_q;
  logic signed [47:0] acc_d;
  logic signed [47:0] diff;
  logic signed [47:0] delta;

  always_comb
  begin
    diff = $signed({port_if.in_pos, 16'h0000}) - acc_q;
    delta = diff >>> port_if.shift;
    // Floor shift stalls short of a rising target, so creep one fraction LSB
    if (delta == 48'sh0 && diff != 48'sh0)
    begin
      delta = 48'sh1;
    end
    acc_d = acc_q + delta;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      acc_q <= 48'sh0;
    end
    else if (port_if.load)
    begin
      acc_q <= $signed({port_if.load_pos, 16'h0000});
    end
    else if (port_if.sample)
    begin
      acc_q <= acc_d;
    end
  end

  assign port_if.out_pos = acc_q[47:16];
endmodule
`default_nettype wire

// File: verification/spo_step_path_properties.sv
// Port-level timing checks of the stepper output path
`timescale 1ns/100ps
`default_nettype none
module spo_step_path_properties
(
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic step_out,
  input wire logic dir_out,
  input wire logic after_profile,
  input wire logic motion_complete
);
  logic acc;
  logic ctl_wr_p_q;
  logic ctl_wr_q;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  assign acc = psel & penable;
  // A motor type write can move either pin two edges after its access cycle
  always_ff @(posedge clock)
  begin
    ctl_wr_p_q <= acc & pwrite & (paddr == 8'h00);
    ctl_wr_q <= ctl_wr_p_q;
  end
  // ----------
  // Assertions
  // ----------
  a_ready_high: assert property (psel |-> pready)
    else $error("pready low during a transfer");
  a_err_unmapped: assert property (acc && paddr > 8'h24 |->
    pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access accepted");
  a_err_mapped: assert property (acc && paddr <= 8'h24 &&
    paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped access refused");
  a_pulse_width:
    assert property ($changed(step_out) |=> $stable(step_out) [*8])
    else $error("step level too short");
  a_dir_setup:
    assert property ($changed(dir_out) && !ctl_wr_q |->
    $stable(step_out) ##1 $stable(step_out) [*8])
    else $error("step follows direction change too soon");
  a_dir_hold:
    assert property ($changed(step_out) && !ctl_wr_q |-> $stable(dir_out))
    else $error("direction moved with step edge");
  a_done_after:
    assert property (motion_complete |-> after_profile)
    else $error("motion complete before profile end");
  a_move_clears:
    assert property (acc && pwrite && paddr == 8'h10 && pwdata != 32'h0
    |-> ##2 (!motion_complete && !after_profile))
    else $error("move did not clear completion");
  c_done: cover property ($rose(motion_complete));
  c_dir: cover property ($changed(dir_out));
  c_err: cover property (acc && pslverr);
endmodule
bind spo_step_path spo_step_path_properties chk (.clock(clock),
  .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b), .step_out(step_out),
  .dir_out(dir_out), .after_profile(after_profile),
  .motion_complete(motion_complete));
`default_nettype wire

// File: verification/spo_step_driver_model.sv
// Step/direction driver with a quadrature encoder on the motor shaft
`timescale 1ns/100ps
`default_nettype none
module spo_step_driver_model
(
  input wire logic clock,
  input wire logic reset,
  input wire logic step_out,
  input wire logic dir_out,
  input wire logic step_act_low,
  output logic enc_a,
  output logic enc_b,
  output var spo_pkg::spo_pos_t pos_q
);
  logic step_prev_q;
  always_ff @(posedge clock)
  begin
    step_prev_q <= step_out;
    if (reset)
      pos_q <= '0;
    else if (step_out != step_prev_q && step_out == !step_act_low)
      pos_q <= dir_out ? pos_q + 32'h1 : pos_q - 32'h1;
  end
  // shaft feedback on main encoder only
  assign enc_a = pos_q[0] ^ pos_q[1];
  assign enc_b = pos_q[1];
endmodule
`default_nettype wire

// File: verification/test_stepper_pulse_output_path.sv
// Register-level bench of the stepper output path
`timescale 1ns/100ps
`default_nettype none
`include "spo_defs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  err_total++; $display("Error t=%0t got %h exp %h", $time, g, e); end end
module test_stepper_pulse_output_path;
  logic clock, reset, psel, penable, pwrite, pready, pslverr, er;
  logic enc_a, enc_b, step_out, dir_out, after_profile, motion_complete;
  logic step_act_low;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  spo_pkg::spo_pos_t pos, p0, dlt;
  int err_total, checks_done, sgn;
  spo_step_path DUT (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .enc_a(enc_a),
    .enc_b(enc_b), .step_out(step_out), .dir_out(dir_out),
    .after_profile(after_profile), .motion_complete(motion_complete));
  spo_step_driver_model drv (.clock(clock), .reset(reset),
    .step_out(step_out), .dir_out(dir_out), .step_act_low(step_act_low),
    .enc_a(enc_a), .enc_b(enc_b), .pos_q(pos));
  always #10 clock = ~clock;
  task automatic print_verdict();
    $display("Checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      err_total++;
      print_verdict();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, er);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, rd, er);
    `CHK(rd, e)
  endtask
  // Slow filter settling can take thousands of cycles
  task automatic wt(input int s, input logic v);
    int n;
    n = 0;
    while (((s == 0) ? after_profile : motion_complete) !== v && n < 40000)
    begin
      @(posedge clock);
      n++;
    end
    if (n >= 40000)
    begin
      err_total++;
      print_verdict();
    end
  endtask
  initial
  begin
    clock = 1'b0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    step_act_low = 1'b0;
    err_total = 0;
    checks_done = 0;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rdchk(`SPO_OFS_CTRL, 32'h0);
    rdchk(`SPO_OFS_STEP_SMOOTH, 32'h4);
    rdchk(`SPO_OFS_PROF_SMOOTH, 32'h0);
    rdchk(`SPO_OFS_SPEED, 32'h3E8);
    rdchk(`SPO_OFS_STATUS, 32'h3);
    wr(`SPO_OFS_REF_POS, 32'h5);
    rdchk(`SPO_OFS_REF_POS, 32'h0);
    rdchk(8'h40, 32'h0);
    `CHK(er, 1'b1)
    // Servo first, then every stepper code; step smoothing 0 is written only with the servo code, which outputs no steps
    for (int m = 0; m < 5; m++)
    begin
      step_act_low <= (m == 1 || m == 3);
      sgn = (m == 0) ? 0 : ((m > 2) ? -1 : 1);
      wr(`SPO_OFS_CTRL, 32'(m));
      wr(`SPO_OFS_STEP_SMOOTH, 32'(m));
      wr(`SPO_OFS_PROF_SMOOTH, 32'(m % 2));
      wr(`SPO_OFS_SPEED, 32'h9);
      wr(`SPO_OFS_DEF_REF, 32'h10);
      wr(`SPO_OFS_ENC_POS, 32'h0);
      rdchk(`SPO_OFS_REF_POS, 32'h10);
      rdchk(`SPO_OFS_STEP_COUNT, 32'h10);
      p0 = pos;
      for (int k = 0; k < 2; k++)
      begin
        wr(`SPO_OFS_MOVE, k ? 32'hFFFFFFFE : 32'h3);
        wt(0, 1'b0);
        wt(0, 1'b1);
        rdchk(`SPO_OFS_REF_POS, k ? 32'h11 : 32'h13);
        if (m != 0)
        begin
          `CHK(motion_complete, 1'b0)
          wt(1, 1'b1);
          rdchk(`SPO_OFS_STEP_COUNT, k ? 32'h11 : 32'h13);
        end
        else
          rdchk(`SPO_OFS_STEP_COUNT, 32'h10);
        dlt = 32'(sgn * (k ? 1 : 3));
        `CHK(pos - p0, dlt)
        rdchk(`SPO_OFS_ENC_POS, dlt);
      end
    end
    print_verdict();
  end
endmodule
`default_nettype wire
